// *** tb/sbsd_receiver_test.sv ***
// Self-checking bench of the serial byte-sync decoder
`timescale 1ns/1ps
`include "sbsd_cfg.svh"
module sbsd_receiver_test;
    import sbsd_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic serial_in_pos, serial_in_neg, cascade_boundary_in;
    logic width_mode_select, test_local_select, req, ack, data_out_strobe;
    logic command_out_strobe, symbol_violation_flag, sync_end_indicator;
    logic byte_clock_out;
    logic [11:0] sym;
    logic [3:0] sym_len;
    sbsd_data_t data_out, last_d;
    sbsd_cmd_t command_out;
    int err_count, num_checks;

    sbsd_receiver uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .serial_in_pos,
        .serial_in_neg, .cascade_boundary_in, .width_mode_select,
        .test_local_select, .data_out, .command_out,
        .data_out_strobe, .command_out_strobe, .symbol_violation_flag,
        .sync_end_indicator, .byte_clock_out);
    sbsd_tx_model tx (.pclk, .presetn, .sym_len, .sym, .req, .ack,
        .serial_in_pos, .serial_in_neg);

    // ------------------------------------------
    // Shared helpers
    // ------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input logic [11:0] s);
        @(posedge pclk);
        sym <= s;
        req <= 1'b1;
        do begin
            @(posedge pclk);
        end while (ack !== 1'b1);
        req <= 1'b0;
    endtask
    task automatic get_d(input sbsd_data_t d, input logic v);
        int i;
        i = 0;
        do begin
            @(posedge pclk);
            #1;
            i++;
        end while (data_out_strobe !== 1'b1 && i < 80);
        chk(data_out_strobe, 1'b1);
        chk(symbol_violation_flag, v);
        chk(command_out, 4'h0);
        if (cascade_boundary_in === 1'b1) chk(sync_end_indicator, 1'b1);
        if (!v) chk(data_out, d);
        if (!v) last_d = d;
    endtask
    task automatic get_c(input sbsd_cmd_t c);
        int i;
        i = 0;
        do begin
            @(posedge pclk);
            #1;
            i++;
        end while (!(command_out_strobe === 1'b1 && command_out !== 4'h0)
                   && i < 80);
        chk(command_out, c);
        chk(data_out, last_d);
    endtask
    function automatic logic [5:0] c6(input logic [4:0] v);
        return {~v[4], SBSD_DATA5[v[3:0]]};
    endfunction
    function automatic logic [11:0] enc(input logic [1:0] m,
                                        input sbsd_data_t d);
        case (m)
            2'h0: return {2'h0, SBSD_DATA5[d[7:4]], SBSD_DATA5[d[3:0]]};
            2'h1: return {1'h0, c6(d[8:4]), SBSD_DATA5[d[3:0]]};
            default: return {c6(d[9:5]), c6(d[4:0])};
        endcase
    endfunction
    function automatic logic [11:0] csym(input logic [1:0] m, input int c);
        case (m)
            2'h0: return 12'(SBSD_CMD8[c]);
            2'h1: return 12'(SBSD_CMD9[c]);
            default: return SBSD_CMD10[c];
        endcase
    endfunction

    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    task automatic t_regs;
        apb(1'b0, `SBSD_CTRL_OFS, 32'h0);
        chk(err, 1'b0);
        chk(rd, 32'h0);
        apb(1'b0, `SBSD_STAT_OFS, 32'h0);
        chk({rd[`SBSD_STAT_VIOL], rd[1:0]}, 3'h0);
        apb(1'b1, 8'h08, 32'h1);
        chk(err, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
    endtask
    task automatic t_test;
        @(posedge pclk);
        test_local_select <= 1'b1;
        repeat (30) @(posedge pclk);
        send(enc(2'h0, 10'h05a));
        get_d(10'h05a, 1'b0);
        repeat (20) @(posedge pclk);
        #1;
        chk(sync_end_indicator, 1'b0);
        @(posedge pclk);
        test_local_select <= 1'b0;
    endtask
    task automatic t_idle;
        int n, b;
        n = 0;
        b = 0;
        for (int i = 0; i < 80 && command_out_strobe !== 1'b1; i++) begin
            @(posedge pclk);
            #1;
        end
        do begin
            @(posedge pclk);
            #1;
            n++;
            b += (byte_clock_out === 1'b1);
        end while (command_out_strobe !== 1'b1 && n < 40);
        chk(n, 32'd10);
        chk(b > 0 && b < 10, 1'b1);
        chk({command_out, sync_end_indicator}, 5'h0);
        apb(1'b0, `SBSD_STAT_OFS, 32'h0);
        chk(rd[`SBSD_STAT_LOCK], 1'b1);
    endtask
    task automatic t_mode(input logic [1:0] m, input sbsd_data_t d);
        // Let the receiver relock in the new width first
        repeat (60) @(posedge pclk);
        apb(1'b0, `SBSD_STAT_OFS, 32'h0);
        chk(rd[1:0], m);
        send(enc(m, d));
        get_d(d, 1'b0);
        for (int c = 1; c < (16 >> m); c++) begin
            send(csym(m, c));
            get_c(4'(c));
        end
    endtask
    task automatic t_burst;
        send(enc(2'h0, 10'h0c3));
        send(enc(2'h0, 10'h03c));
        get_d(10'h0c3, 1'b0);
        get_d(10'h03c, 1'b0);
        @(posedge pclk);
        cascade_boundary_in <= 1'b0;
        get_d(10'h03c, 1'b0);
        repeat (2) @(posedge pclk);
        #1;
        chk(sync_end_indicator, 1'b0);
        @(posedge pclk);
        cascade_boundary_in <= 1'b1;
        send(12'h021);
        get_d(10'h0, 1'b1);
        apb(1'b0, `SBSD_STAT_OFS, 32'h0);
        chk(rd[`SBSD_STAT_VIOL], 1'b1);
        apb(1'b1, `SBSD_STAT_OFS, 32'h10);
        apb(1'b0, `SBSD_STAT_OFS, 32'h0);
        chk(rd[`SBSD_STAT_VIOL], 1'b0);
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #400000;
        err_count++;
        conclude;
    end
    initial begin
        {presetn, psel, penable, pwrite, req, width_mode_select} = 6'h0;
        test_local_select = 1'b0;
        {paddr, pwdata, sym, last_d} = '0;
        cascade_boundary_in = 1'b1;
        sym_len = 4'ha;
        err_count = 0;
        num_checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_idle;
        t_mode(2'h0, 10'h0a5);
        t_burst;
        t_test;
        @(posedge pclk);
        width_mode_select <= 1'b1;
        sym_len <= 4'hb;
        t_mode(2'h1, 10'h15a);
        apb(1'b1, `SBSD_CTRL_OFS, 32'h1);
        @(posedge pclk);
        sym_len <= 4'hc;
        t_mode(2'h2, 10'h2c3);
        conclude;
    end
endmodule

// *** tb/sbsd_tx_model.sv ***
// Serial transmitter model that feeds the receiver under test
`timescale 1ns/1ps
module sbsd_tx_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] sym_len,
    input wire logic [11:0] sym,
    input wire logic req,
    output logic ack,
    output logic serial_in_pos,
    output logic serial_in_neg
);
    import sbsd_pkg::*;
    logic [11:0] shift_q;
    logic [3:0] cnt_q;
    logic [11:0] sync_w;
    logic bit_w;

    // ------------------------------------------
    // Symbol shifter, MSB first
    // ------------------------------------------
    // 8 and 9 bit Sync share one value
    assign sync_w = (sym_len == 4'hc) ? SBSD_CMD10[0] :
        12'(SBSD_CMD8[0]);
    assign bit_w = shift_q[sym_len - 4'h1];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= 12'h0;
            cnt_q <= 4'h0;
            ack <= 1'b0;
            serial_in_pos <= 1'b0;
            serial_in_neg <= 1'b1;
        end else begin
            ack <= 1'b0;
            serial_in_pos <= bit_w;
            serial_in_neg <= ~bit_w;
            if (cnt_q == sym_len - 4'h1) begin
                cnt_q <= 4'h0;
                // Idle bytes carry Sync so the far end keeps lock
                shift_q <= req ? sym : sync_w;
                ack <= req;
            end else begin
                cnt_q <= cnt_q + 4'h1;
                shift_q <= {shift_q[10:0], 1'b0};
            end
        end
    end
endmodule

// *** verilog/sbsd_cfg.svh ***
// Constants of the serial byte-sync decoder
`ifndef SBSD_CFG_SVH
`define SBSD_CFG_SVH

`define SBSD_SYNC_STAGES 3
`define SBSD_CNT_RST 4'h0
`define SBSD_CNT_ONE 4'h1
`define SBSD_LEN8 4'ha
`define SBSD_LEN9 4'hb
`define SBSD_LEN10 4'hc
`define SBSD_HALF8 4'h5
`define SBSD_HALF10 4'h6
`define SBSD_SYNC8 10'h311
`define SBSD_SYNC9 11'h311
`define SBSD_SYNC10 12'h623
`define SBSD_SYNC_HI8 5'h18
`define SBSD_SYNC_HI10 6'h18
`define SBSD_SYNC_CMD 4'h0

`define SBSD_ADDR_W 8
`define SBSD_CTRL_OFS 8'h00
`define SBSD_STAT_OFS 8'h04
`define SBSD_CTRL_TEN 0
`define SBSD_STAT_VIOL 4
`define SBSD_STAT_LOCK 3
`define SBSD_STAT_SEND 2

`endif

// *** verilog/sbsd_dec_if.sv ***
// Symbol and decode result between receiver core and decoder
`timescale 1ns/1ps
interface sbsd_dec_if;
    import sbsd_pkg::*;
    sbsd_mode_e mode;
    sbsd_sym_t sym;
    sbsd_data_t data;
    sbsd_cmd_t cmd;
    logic is_cmd;
    logic is_sync;
    logic viol;
    modport dec (input mode, input sym, output data, output cmd,
                 output is_cmd, output is_sync, output viol);
    modport core (output mode, output sym, input data, input cmd,
                  input is_cmd, input is_sync, input viol);
endinterface

// *** verilog/sbsd_decoder.sv ***
// Symbol decoder: data, command, sync and violation
`timescale 1ns/1ps
`include "sbsd_cfg.svh"
module sbsd_decoder (
    sbsd_dec_if.dec p
);
    import sbsd_pkg::*;

    function automatic logic [4:0] dec5(input logic [4:0] c);
        logic [4:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            if (SBSD_DATA5[i] == c) begin
                r = {1'h1, 4'(i)};
            end
        end
        return r;
    endfunction

    // Six-bit code: leading bit set means data bit four clear
    function automatic logic [5:0] dec6(input logic [5:0] c);
        logic [4:0] n;
        n = dec5(c[4:0]);
        return {n[4], ~c[5], n[3:0]};
    endfunction

    always_comb begin
        logic [4:0] a5;
        logic [4:0] b5;
        logic [5:0] a6;
        logic [5:0] b6;
        logic ok;
        logic hit;
        a5 = dec5(p.sym[9:5]);
        b5 = dec5(p.sym[4:0]);
        a6 = dec6(p.sym[11:6]);
        b6 = dec6(p.sym[5:0]);
        a6 = (p.mode == SBSD_MODE_9) ? dec6(p.sym[10:5]) : a6;
        ok = 1'h0;
        hit = 1'h0;
        p.data = '0;
        p.cmd = '0;
        // Command match takes precedence over a data match
        unique case (p.mode)
            SBSD_MODE_8: begin
                for (int i = 0; i < 16; i++) begin
                    if (p.sym[9:0] == SBSD_CMD8[i]) begin
                        hit = 1'h1;
                        p.cmd = 4'(i);
                    end
                end
                p.data = {2'h0, a5[3:0], b5[3:0]};
                ok = a5[4] & b5[4];
            end
            SBSD_MODE_9: begin
                for (int i = 0; i < 8; i++) begin
                    if (p.sym[10:0] == SBSD_CMD9[i]) begin
                        hit = 1'h1;
                        p.cmd = 4'(i);
                    end
                end
                p.data = {1'h0, a6[4:0], b5[3:0]};
                ok = a6[5] & b5[4];
            end
            SBSD_MODE_10: begin
                for (int i = 0; i < 4; i++) begin
                    if (p.sym == SBSD_CMD10[i]) begin
                        hit = 1'h1;
                        p.cmd = 4'(i);
                    end
                end
                p.data = {a6[4:0], b6[4:0]};
                ok = a6[5] & b6[5];
            end
            default: begin
                ok = 1'h0;
            end
        endcase
        p.is_cmd = hit;
        p.is_sync = hit && (p.cmd == `SBSD_SYNC_CMD);
        p.viol = !hit && !ok;
    end
endmodule

// *** verilog/sbsd_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "sbsd_cfg.svh"
module sbsd_pin_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;

    if (W < 1) begin : g_chk
        $error("sbsd_pin_sync: W must be at least 1");
    end

    // Stage one feeds stage two only, never the filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q <= '0;
        end else begin
            lvl_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
        end
    end

    assign level_out = lvl_q;
endmodule

// *** verilog/sbsd_pkg.sv ***
// Types and code tables of the serial byte-sync decoder
package sbsd_pkg;
    typedef enum logic [1:0] {SBSD_MODE_8, SBSD_MODE_9, SBSD_MODE_10} sbsd_mode_e;
    typedef logic [11:0] sbsd_sym_t;
    typedef logic [9:0] sbsd_data_t;
    typedef logic [3:0] sbsd_cmd_t;

    // Five-bit data codes, indexed by nibble value
    localparam logic [4:0] SBSD_DATA5 [16] = '{
        5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    // Command symbols, indexed by command value; entry 0 is Sync
    localparam logic [9:0] SBSD_CMD8 [16] = '{
        10'h311, 10'h3ff, 10'h1ad, 10'h1b9, 10'h3e4, 10'h1a7, 10'h327,
        10'h339, 10'h084, 10'h09f, 10'h080, 10'h0e7, 10'h0f9, 10'h004,
        10'h01f, 10'h000};
    localparam logic [10:0] SBSD_CMD9 [8] = '{
        11'h311, 11'h7ff, 11'h3ad, 11'h3b9, 11'h7e4, 11'h3a7, 11'h727,
        11'h739};
    localparam logic [11:0] SBSD_CMD10 [4] = '{
        12'h623, 12'hfff, 12'h75d, 12'h779};
endpackage

// *** verilog/sbsd_receiver.sv ***
// Serial link receiver: byte sync, symbol decode, output latch
`timescale 1ns/1ps
`include "sbsd_cfg.svh"

// What this block does
// - Bit clock is ten, eleven or twelve times the byte rate.
// - Every bit clock shifts one serial bit into the shift register.
// - A found Sync code restarts the bit counter marking byte boundaries.
// - Byte clock output comes from the shifter-to-decoder transfer timing.
// - Outputs update at boundary, on cascade fall, or on Sync.
// - Test mode raises sync-end when first byte after Sync transfers.
// - Sync-end falls on first half of Sync or cascade low.
// - Sync-end rises on first half of non-Sync byte if cascade high.
// - Sync-end rises six or seven bit clocks before the data appears.
// - Decoder latch loads from the shift register at every boundary.
// - Symbols decode to 8/9/10 bit data or 4/3/2 bit commands.
// - Data and command symbols raise their own strobe.
// - Data only changes data outputs, command only command outputs.
// - Sync is a command, so idle links still give command strobes.
// - Undecodable symbols are violations but still give one strobe.
// - Width select low means 8-bit mode, high means 9-bit mode.
// - Test/local select low means local mode.
module sbsd_receiver (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in_pos,
    input wire logic serial_in_neg,
    input wire logic cascade_boundary_in,
    input wire logic width_mode_select,
    input wire logic test_local_select,
    output sbsd_pkg::sbsd_data_t data_out,
    output sbsd_pkg::sbsd_cmd_t command_out,
    output logic data_out_strobe,
    output logic command_out_strobe,
    output logic symbol_violation_flag,
    output logic sync_end_indicator,
    output logic byte_clock_out
);
    import sbsd_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisation and mode
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic casc_s;
    logic wms_s;
    logic tls_s;
    logic rx_bit;
    sbsd_mode_e mode_q;
    logic test_q;
    logic ten_q;

    // Slow level pins only
    sbsd_pin_sync #(.W(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({cascade_boundary_in, width_mode_select,
                 test_local_select}),
        .level_out(pins_s)
    );

    assign {casc_s, wms_s, tls_s} = pins_s;
    // Serial bits arrive on the bit clock; the agreement filter
    // would swallow every lone bit, so they bypass it
    // A non-differential pair reads as zero
    assign rx_bit = serial_in_pos & ~serial_in_neg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= SBSD_MODE_8;
        end else if (ten_q) begin
            mode_q <= SBSD_MODE_10;
        end else begin
            mode_q <= wms_s ? SBSD_MODE_9 : SBSD_MODE_8;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_q <= 1'h0;
        end else begin
            test_q <= tls_s;
        end
    end

    // ----------------------------------------------------------------
    // Shifter and byte sync
    // ----------------------------------------------------------------
    sbsd_sym_t shift_q;
    sbsd_sym_t dec_q;
    logic [3:0] bcnt_q;
    logic [3:0] len_w;
    logic [3:0] half_w;
    logic sync_hit;
    logic hi_sync;
    logic bnd;
    logic fh_sync;
    logic fh_nonsync;
    logic ld_q;
    logic locked_q;

    // Symbol length sets the bit-to-byte ratio
    always_comb begin
        len_w = `SBSD_LEN8;
        half_w = `SBSD_HALF8;
        sync_hit = shift_q[9:0] == `SBSD_SYNC8;
        hi_sync = shift_q[4:0] == `SBSD_SYNC_HI8;
        unique case (mode_q)
            SBSD_MODE_8: begin
                len_w = `SBSD_LEN8;
            end
            SBSD_MODE_9: begin
                len_w = `SBSD_LEN9;
                half_w = `SBSD_HALF10;
                sync_hit = shift_q[10:0] == `SBSD_SYNC9;
                hi_sync = shift_q[5:0] == `SBSD_SYNC_HI10;
            end
            SBSD_MODE_10: begin
                len_w = `SBSD_LEN10;
                half_w = `SBSD_HALF10;
                sync_hit = shift_q == `SBSD_SYNC10;
                hi_sync = shift_q[5:0] == `SBSD_SYNC_HI10;
            end
            default: begin
                len_w = `SBSD_LEN8;
            end
        endcase
    end

    // Counter above length covers a mode change mid-symbol
    assign bnd = sync_hit || (bcnt_q >= len_w);
    assign fh_sync = (bcnt_q == half_w) && hi_sync;
    assign fh_nonsync = (bcnt_q == half_w) && !hi_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= '0;
        end else begin
            shift_q <= {shift_q[10:0], rx_bit};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_q <= `SBSD_CNT_RST;
        end else if (bnd) begin
            bcnt_q <= `SBSD_CNT_ONE;
        end else begin
            bcnt_q <= bcnt_q + `SBSD_CNT_ONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_q <= '0;
            ld_q <= 1'h0;
        end else begin
            ld_q <= bnd;
            if (bnd) begin
                dec_q <= shift_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_q <= 1'h0;
        end else if (sync_hit) begin
            locked_q <= 1'h1;
        end
    end

    // ----------------------------------------------------------------
    // Decoder and output latch
    // ----------------------------------------------------------------
    sbsd_dec_if dec ();
    logic casc_prev_q;
    logic out_go;
    logic after_sync_q;
    sbsd_data_t data_q;
    sbsd_cmd_t cmd_q;
    logic data_out_strobe_q;
    logic command_out_strobe_q;
    logic viol_q;
    logic se_q;
    logic bclk_q;

    assign dec.mode = mode_q;
    assign dec.sym = dec_q;

    sbsd_decoder u_dec (
        .p(dec)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            casc_prev_q <= 1'h0;
        end else begin
            casc_prev_q <= casc_s;
        end
    end

    assign out_go = ld_q || (casc_prev_q && !casc_s);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= '0;
            cmd_q <= '0;
            data_out_strobe_q <= 1'h0;
            command_out_strobe_q <= 1'h0;
            viol_q <= 1'h0;
        end else begin
            data_out_strobe_q <= out_go && !dec.is_cmd;
            command_out_strobe_q <= out_go && dec.is_cmd;
            viol_q <= out_go && dec.viol;
            if (out_go && dec.is_cmd) begin
                cmd_q <= dec.cmd;
            end
            if (out_go && !dec.is_cmd) begin
                data_q <= dec.data;
            end
        end
    end

    // Byte clock high for the first half of each symbol
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_q <= 1'h0;
        end else if (bnd) begin
            bclk_q <= 1'h1;
        end else if (bcnt_q == half_w) begin
            bclk_q <= 1'h0;
        end
    end

    // Local mode watches half-symbols, so it leads the output by six or seven bit clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            se_q <= 1'h0;
            after_sync_q <= 1'h0;
        end else begin
            if (out_go) begin
                after_sync_q <= dec.is_sync;
            end
            if (!casc_s) begin
                se_q <= 1'h0;
            end else if (test_q) begin
                if (out_go) begin
                    se_q <= after_sync_q && !dec.is_sync;
                end
            end else if (fh_sync) begin
                se_q <= 1'h0;
            end else if (fh_nonsync) begin
                se_q <= 1'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // APB registers
    // ----------------------------------------------------------------
    logic [31:0] rdata_q;
    logic ready_q;
    logic err_q;
    logic viol_st_q;
    logic hit_ctrl;
    logic hit_stat;
    logic wr_en;

    assign hit_ctrl = paddr == `SBSD_CTRL_OFS;
    assign hit_stat = paddr == `SBSD_STAT_OFS;
    assign wr_en = psel && penable && ready_q && pwrite;

    // Answer in the first access cycle, read data sampled at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'h0;
            err_q <= 1'h0;
            rdata_q <= '0;
        end else begin
            ready_q <= psel && !penable;
            err_q <= psel && !penable && !hit_ctrl && !hit_stat;
            if (psel && !penable) begin
                rdata_q <= '0;
                if (hit_ctrl) begin
                    rdata_q[`SBSD_CTRL_TEN] <= ten_q;
                end
                if (hit_stat) begin
                    rdata_q[1:0] <= mode_q;
                    rdata_q[`SBSD_STAT_SEND] <= se_q;
                    rdata_q[`SBSD_STAT_LOCK] <= locked_q;
                    rdata_q[`SBSD_STAT_VIOL] <= viol_st_q;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ten_q <= 1'h0;
        end else if (wr_en && hit_ctrl) begin
            ten_q <= pwdata[`SBSD_CTRL_TEN];
        end
    end

    // A new violation beats a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            viol_st_q <= 1'h0;
        end else if (viol_q) begin
            viol_st_q <= 1'h1;
        end else if (wr_en && hit_stat && pwdata[`SBSD_STAT_VIOL]) begin
            viol_st_q <= 1'h0;
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign data_out = data_q;
    assign command_out = cmd_q;
    assign data_out_strobe = data_out_strobe_q;
    assign command_out_strobe = command_out_strobe_q;
    assign symbol_violation_flag = viol_q;
    assign sync_end_indicator = se_q;
    assign byte_clock_out = bclk_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    shift_in_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##3 shift_q[2] == $past(rx_bit, 3))
        else $error("serial bit not shifted in");
    sync_restart_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sync_hit |=> bcnt_q == `SBSD_CNT_ONE ##1 dec_q == $past(shift_q, 2))
        else $error("sync did not restart byte count");
    period_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (bcnt_q == len_w) |=> ld_q && dec_q == $past(shift_q))
        else $error("byte boundary missed");
    bclk_rise_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(bclk_q) |-> $past(bnd) && ld_q)
        else $error("byte clock not aligned with transfer");
    out_strobe_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ld_q |=> data_out_strobe_q ^ command_out_strobe_q)
        else $error("transfer gave no single strobe");
    data_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        command_out_strobe_q |-> $stable(data_q))
        else $error("command disturbed data outputs");
    cmd_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        data_out_strobe_q |-> $stable(cmd_q))
        else $error("data disturbed command outputs");
    sync_cmd_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ld_q && dec.is_sync |=> command_out_strobe_q && cmd_q == `SBSD_SYNC_CMD)
        else $error("sync gave no command strobe");
    viol_strobe_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        viol_q |-> (data_out_strobe_q || command_out_strobe_q) && !$past(dec.is_cmd))
        else $error("violation without strobe");
    se_low_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !casc_s |=> !se_q)
        else $error("sync-end high with cascade low");
    se_rise_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !test_q && casc_s && fh_nonsync |=> se_q)
        else $error("sync-end did not rise");
    se_test_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        test_q && casc_s && out_go && after_sync_q && !dec.is_sync |=> se_q)
        else $error("test-mode sync-end missing");
endmodule
